// *** cbdhr_consts.svh ***
// constants for the cpu bus decode and halt reset glue
// assumes a 125 MHz mclk and a 20-bit memory / 16-bit io address space
`ifndef CBDHR_CONSTS_SVH
`define CBDHR_CONSTS_SVH
`define CBDHR_UPPER_LO 20'hFF800
`define CBDHR_UPPER_HI 20'hFFFFF
`define CBDHR_RAM_LO 20'h02000
`define CBDHR_RAM_HI 20'h020FF
`define CBDHR_LOWER_LO 20'h00000
`define CBDHR_LOWER_HI 20'h007FF
`define CBDHR_PERIPH_BASE 16'h0000
`define CBDHR_PERIPH_BLOCK_SHIFT 7
`define CBDHR_HALT_CODE 3'h3
`define CBDHR_FETCH_ADDR 20'hFFFF0
`define CBDHR_RST_STATUS 16'hF002
`define CBDHR_RST_CODE_SEG 16'hFFFF
`define CBDHR_RST_RELOC 16'h20FF
`define CBDHR_RST_ZERO 16'h0000
`define CBDHR_RST_UPPER_CFG 16'hFFFB
`define CBDHR_PORT_RST 8'h00
`define CBDHR_BUS_IDLE 35'h300000007
`define CBDHR_CLK_MHZ 125
`define CBDHR_PULSE_MS 40
`define CBDHR_POR_MS 50
`endif

// *** cbdhr_cpu_model.sv ***
// processor side of the glue: runs one bus cycle per call of run_cycle
// assumes the bench calls run_cycle from a single process, off reset
module cbdhr_cpu_model (
    input wire logic mclk,
    output cbdhr_pkg::cbdhr_bus_t bus,
    output logic sample_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        bus = '0;
        bus.rd_n = 1'b1;
        bus.wr_n = 1'b1;
        bus.state_n = 3'h7;
        sample_pulse = 1'b0;
    end
    task automatic run_cycle(input logic io, input logic [19:0] a, input logic wr, input logic [7:0] d,
                             input logic [2:0] st);
        @(negedge mclk);
        bus.ale <= 1'b1;
        bus.is_io <= io;
        bus.addr <= a;
        bus.wdata <= ~d;
        bus.state_n <= st;
        repeat (2) @(negedge mclk);
        bus.ale <= 1'b0;
        repeat (3) @(negedge mclk);
        // address phase over: lines now carry other values, so a missed latch shows
        bus.addr <= ~a;
        bus.state_n <= 3'h7;
        if (wr) begin
            bus.wdata <= d;
            bus.wr_n <= 1'b0;
        end else begin
            bus.rd_n <= 1'b0;
        end
        repeat (6) @(negedge mclk);
        sample_pulse <= 1'b1;
        @(negedge mclk);
        sample_pulse <= 1'b0;
        bus.rd_n <= 1'b1;
        bus.wr_n <= 1'b1;
        bus.wdata <= ~d;
        repeat (4) @(negedge mclk);
    endtask : run_cycle
endmodule : cbdhr_cpu_model

// *** cbdhr_pkg.sv ***
// types for the cpu bus decode and halt reset glue
// assumes the constants header is included by users
package cbdhr_pkg;
    typedef struct packed {
        logic ale;
        logic rd_n;
        logic wr_n;
        logic is_io;
        logic [19:0] addr;
        logic [7:0] wdata;
        logic [2:0] state_n;
    } cbdhr_bus_t;
    typedef struct packed {
        logic [15:0] status;
        logic [15:0] ip;
        logic [15:0] cs;
        logic [15:0] ds;
        logic [15:0] es;
        logic [15:0] ss;
        logic [15:0] reloc;
        logic [15:0] upper_cfg;
        logic [19:0] fetch;
    } cbdhr_rstval_t;
    typedef enum logic [2:0] {
        CBDHR_IDLE = 3'b001,
        CBDHR_ARMED = 3'b010,
        CBDHR_PULSE = 3'b100
    } cbdhr_state_t;
endpackage : cbdhr_pkg

// *** cbdhr_top.sv ***
// bus decode, port latches and halt reset sequencing for one controller
// assumes the cpu strobes come from pins and pass a two-stage synchroniser
// Notes on behaviour
// - decode upper, ram, lower eprom memory ranges
// - upper select enables upper eprom on read
// - address captured on falling latch strobe
// - eprom memory read drives data while read low
// - io 0000-007F selects upper eprom ports
// - low address bits pick port or direction
// - port write works only on io cycles, not memory
// - port read drives port bits; no direction
// - dedicated port read strobe tied inactive
// - output bits read back from latch
// - lower eprom has own selects and port latches, shares upper direction registers
// - ram enabled high from midrange select
// - ram io/memory input low for memory
// - ram read drives, write stores latched byte
// - halt pattern 0,1,1 sampled at latch fall
// - halt arms, clock low triggers, shot rearms
// - one-shot gives tens of millisecond pulse
// - either halt resets both controllers
// - host command or switch change triggers shot
// - power-on holds reset about 50 ms
// - fetch starts at FFFF0 after reset
// - reset loads documented register values
// - each periph select covers 128 addresses
`include "cbdhr_consts.svh"
module cbdhr_top #(
    parameter int PULSE_CYCLES = `CBDHR_PULSE_MS * `CBDHR_CLK_MHZ * 1000,
    parameter int POR_CYCLES = `CBDHR_POR_MS * `CBDHR_CLK_MHZ * 1000
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire cbdhr_pkg::cbdhr_bus_t bus_in,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_b_in,
    input wire logic [7:0] lo_port_a_in,
    input wire logic [7:0] lo_port_b_in,
    input wire logic [7:0] eprom_rdata,
    input wire logic [7:0] ram_rdata,
    input wire logic other_halt,
    input wire logic host_reset_cmd,
    input wire logic manual_computer_switch,
    output logic upper_memory_select_n,
    output logic lower_memory_select_n,
    output logic midrange_select0_n,
    output logic periph_select0_n,
    output logic periph_select1_n,
    output logic periph_select2_n,
    output logic periph_select3_n,
    output logic ram_chip_en,
    output logic ram_io_mem,
    output logic port_read_strobe_n,
    output logic [7:0] rdata,
    output logic rdata_oe,
    output logic [7:0] port_a_out,
    output logic [7:0] port_b_out,
    output logic [7:0] port_a_dir,
    output logic [7:0] port_b_dir,
    output logic [7:0] lo_port_a_out,
    output logic [7:0] lo_port_b_out,
    output logic halt_out,
    output logic cpu_reset_in_n,
    output logic focus_reset_out,
    output logic rotation_reset_out,
    output cbdhr_pkg::cbdhr_rstval_t cpu_rstval
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    cbdhr_pkg::cbdhr_bus_t bus_m_q, bus_q;
    logic [2:0] ext_m_q, ext_q;
    logic [47:0] din_m_q, din_q;
    logic ale_d1_q, sw_d1_q;
    wire reset_pulse;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            // idle strobes, so no bus cycle shows as reset lifts
            bus_m_q <= `CBDHR_BUS_IDLE;
            bus_q <= `CBDHR_BUS_IDLE;
            ext_m_q <= 3'h0;
            ext_q <= 3'h0;
            din_m_q <= 48'h0;
            din_q <= 48'h0;
        end else begin
            bus_m_q <= bus_in;
            bus_q <= bus_m_q;
            ext_m_q <= {other_halt, host_reset_cmd, manual_computer_switch};
            ext_q <= ext_m_q;
            din_m_q <= {port_a_in, port_b_in, lo_port_a_in, lo_port_b_in, eprom_rdata, ram_rdata};
            din_q <= din_m_q;
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ale_d1_q <= 1'b0;
            sw_d1_q <= 1'b0;
        end else begin
            ale_d1_q <= bus_q.ale;
            sw_d1_q <= ext_q[0];
        end
    end
    wire ale_fall = ale_d1_q & ~bus_q.ale;
    wire [7:0] pa_pin = din_q[47:40];
    wire [7:0] pb_pin = din_q[39:32];
    wire [7:0] lpa_pin = din_q[31:24];
    wire [7:0] lpb_pin = din_q[23:16];
    wire [7:0] ep_pin = din_q[15:8];
    wire [7:0] ram_pin = din_q[7:0];

    // ------------------------------------------------------------
    // address latch and decode
    // ------------------------------------------------------------
    logic [19:0] addr_q;
    logic io_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            addr_q <= 20'h00000;
            io_q <= 1'b0;
        end else if (ale_fall) begin
            addr_q <= bus_q.addr;
            io_q <= bus_q.is_io;
        end
    end
    function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range
    wire [15:0] io_off = addr_q[15:0] - `CBDHR_PERIPH_BASE;
    wire [8:0] io_blk = io_off[15:`CBDHR_PERIPH_BLOCK_SHIFT];
    wire mem_up = !io_q && in_range(addr_q, `CBDHR_UPPER_LO, `CBDHR_UPPER_HI);
    wire mem_ram = !io_q && in_range(addr_q, `CBDHR_RAM_LO, `CBDHR_RAM_HI);
    wire mem_lo = !io_q && in_range(addr_q, `CBDHR_LOWER_LO, `CBDHR_LOWER_HI);
    wire io_ok = io_q && (addr_q[19:16] == 4'h0);
    wire ps0 = io_ok && (io_blk == 9'h000);
    wire ps1 = io_ok && (io_blk == 9'h001);
    wire ps2 = io_ok && (io_blk == 9'h002);
    wire ps3 = io_ok && (io_blk == 9'h003);
    wire cyc = !bus_q.rd_n || !bus_q.wr_n;
    wire rd = !bus_q.rd_n;
    wire wr_fall = !bus_q.wr_n;
    wire [1:0] psel = addr_q[1:0];

    // ------------------------------------------------------------
    // port latches for both eprom chips, direction registers shared
    // ------------------------------------------------------------
    logic [7:0] pa_q, pb_q, da_q, db_q, lpa_q, lpb_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pa_q <= `CBDHR_PORT_RST;
            pb_q <= `CBDHR_PORT_RST;
            da_q <= `CBDHR_PORT_RST;
            db_q <= `CBDHR_PORT_RST;
            lpa_q <= `CBDHR_PORT_RST;
            lpb_q <= `CBDHR_PORT_RST;
        end else if (reset_pulse) begin
            pa_q <= `CBDHR_PORT_RST;
            pb_q <= `CBDHR_PORT_RST;
            da_q <= `CBDHR_PORT_RST;
            db_q <= `CBDHR_PORT_RST;
            lpa_q <= `CBDHR_PORT_RST;
            lpb_q <= `CBDHR_PORT_RST;
        end else if (wr_fall && (ps0 || ps1)) begin
            unique case ({ps1, psel})
                3'b000: pa_q <= bus_q.wdata;
                3'b001: pb_q <= bus_q.wdata;
                3'b010: da_q <= bus_q.wdata;
                3'b011: db_q <= bus_q.wdata;
                3'b100: lpa_q <= bus_q.wdata;
                3'b101: lpb_q <= bus_q.wdata;
                // lower chip shares the direction registers, it has no direction registers of its own
                3'b110: da_q <= bus_q.wdata;
                3'b111: db_q <= bus_q.wdata;
            endcase
        end
    end
    // output bits read back from the latch, input bits from the pin
    function automatic logic [7:0] port_view(input logic [7:0] lat, input logic [7:0] pin, input logic [7:0] dir);
        port_view = (lat & dir) | (pin & ~dir);
    endfunction : port_view
    wire [7:0] up_port = psel[0] ? port_view(pb_q, pb_pin, db_q) : port_view(pa_q, pa_pin, da_q);
    wire [7:0] lo_port = psel[0] ? port_view(lpb_q, lpb_pin, db_q) : port_view(lpa_q, lpa_pin, da_q);
    wire port_rd = rd && (ps0 || ps1) && !psel[1];
    wire mem_rd = rd && (mem_up || mem_lo || mem_ram);
    wire [7:0] rd_mux = port_rd ? (ps1 ? lo_port : up_port) : (mem_ram ? ram_pin : ep_pin);

    // ------------------------------------------------------------
    // registered chip selects and read data
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            upper_memory_select_n <= 1'b1;
            lower_memory_select_n <= 1'b1;
            midrange_select0_n <= 1'b1;
            periph_select0_n <= 1'b1;
            periph_select1_n <= 1'b1;
            periph_select2_n <= 1'b1;
            periph_select3_n <= 1'b1;
            ram_chip_en <= 1'b0;
            ram_io_mem <= 1'b0;
            port_read_strobe_n <= 1'b1;
            rdata <= 8'h00;
            rdata_oe <= 1'b0;
        end else begin
            upper_memory_select_n <= !(cyc && (mem_up || ps0));
            lower_memory_select_n <= !(cyc && (mem_lo || ps1));
            midrange_select0_n <= !(cyc && mem_ram);
            periph_select0_n <= !(cyc && ps0);
            periph_select1_n <= !(cyc && ps1);
            periph_select2_n <= !(cyc && ps2);
            periph_select3_n <= !(cyc && ps3);
            ram_chip_en <= cyc && (mem_ram || ps2);
            ram_io_mem <= ps2;
            port_read_strobe_n <= 1'b1;
            rdata <= rd_mux;
            rdata_oe <= mem_rd || port_rd;
        end
    end

    // ------------------------------------------------------------
    // halt detect, reset one-shot, power-on hold
    // ------------------------------------------------------------
    wire halt_seen = ale_fall && (bus_q.state_n == `CBDHR_HALT_CODE);
    wire sw_edge = ext_q[0] ^ sw_d1_q;
    wire trig_ext = ext_q[1] || ext_q[2] || sw_edge;
    cbdhr_pkg::cbdhr_state_t st_q;
    logic [31:0] cnt_q;
    logic [31:0] por_q;
    logic por_done_q;
    assign reset_pulse = (st_q == cbdhr_pkg::CBDHR_PULSE);
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_q <= cbdhr_pkg::CBDHR_IDLE;
            cnt_q <= 32'h0;
        end else begin
            unique case (st_q)
                cbdhr_pkg::CBDHR_IDLE: begin
                    if (trig_ext) begin
                        st_q <= cbdhr_pkg::CBDHR_PULSE;
                    end else if (halt_seen) begin
                        st_q <= cbdhr_pkg::CBDHR_ARMED;
                    end
                    cnt_q <= 32'h0;
                end
                cbdhr_pkg::CBDHR_ARMED: begin
                    st_q <= cbdhr_pkg::CBDHR_PULSE;
                end
                cbdhr_pkg::CBDHR_PULSE: begin
                    if (cnt_q == 32'(PULSE_CYCLES - 1)) begin
                        st_q <= cbdhr_pkg::CBDHR_IDLE;
                    end
                    cnt_q <= cnt_q + 32'h1;
                end
                default: st_q <= cbdhr_pkg::CBDHR_IDLE;
            endcase
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            por_q <= 32'h0;
            por_done_q <= 1'b0;
        end else if (!por_done_q) begin
            por_q <= por_q + 32'h1;
            por_done_q <= (por_q == 32'(POR_CYCLES - 1));
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cpu_reset_in_n <= 1'b0;
            focus_reset_out <= 1'b1;
            rotation_reset_out <= 1'b1;
            halt_out <= 1'b0;
        end else begin
            cpu_reset_in_n <= por_done_q && !reset_pulse;
            focus_reset_out <= !por_done_q || reset_pulse;
            rotation_reset_out <= !por_done_q || reset_pulse;
            halt_out <= (st_q == cbdhr_pkg::CBDHR_ARMED);
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cpu_rstval <= '0;
        end else begin
            cpu_rstval <= '{`CBDHR_RST_STATUS, `CBDHR_RST_ZERO, `CBDHR_RST_CODE_SEG, `CBDHR_RST_ZERO,
                `CBDHR_RST_ZERO, `CBDHR_RST_ZERO, `CBDHR_RST_RELOC, `CBDHR_RST_UPPER_CFG,
                `CBDHR_FETCH_ADDR};
        end
    end
    assign port_a_out = pa_q;
    assign port_b_out = pb_q;
    assign port_a_dir = da_q;
    assign port_b_dir = db_q;
    assign lo_port_a_out = lpa_q;
    assign lo_port_b_out = lpb_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_halt_fall;
        ale_fall && bus_q.state_n == 3'h3;
    endsequence
    AST_HALT_TRIGGERS: assert property (@(posedge mclk) disable iff (!resetn)
        (st_q == cbdhr_pkg::CBDHR_IDLE && !trig_ext) and s_halt_fall |=> st_q == cbdhr_pkg::CBDHR_ARMED ##1 reset_pulse)
        else $error("halt did not start reset pulse");
    AST_PULSE_HOLDS: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(reset_pulse) |=> reset_pulse [*8])
        else $error("reset pulse too short");
    AST_RESET_LOW: assert property (@(posedge mclk) disable iff (!resetn)
        reset_pulse |=> !cpu_reset_in_n && focus_reset_out && rotation_reset_out)
        else $error("reset outputs not driven");
    AST_EXT_TRIG: assert property (@(posedge mclk) disable iff (!resetn)
        st_q == cbdhr_pkg::CBDHR_IDLE && trig_ext |=> reset_pulse)
        else $error("host or switch did not reset");
    AST_POR_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
        !por_done_q |=> !cpu_reset_in_n)
        else $error("cpu left reset before power-on time");
    AST_UNMAPPED: assert property (@(posedge mclk) disable iff (!resetn)
        !(mem_up || mem_lo || mem_ram || ps0 || ps1 || ps2 || ps3) |=> !rdata_oe && upper_memory_select_n
        && lower_memory_select_n && midrange_select0_n && !ram_chip_en)
        else $error("undecoded access selected a chip");
    AST_RAM_EN: assert property (@(posedge mclk) disable iff (!resetn)
        cyc && mem_ram |=> ram_chip_en && !ram_io_mem && !midrange_select0_n)
        else $error("ram not enabled for memory cycle");
    AST_PS0_UPPER: assert property (@(posedge mclk) disable iff (!resetn)
        cyc && ps0 |=> !upper_memory_select_n && !periph_select0_n)
        else $error("port cycle did not enable upper eprom");
    AST_DIR_NOREAD: assert property (@(posedge mclk) disable iff (!resetn)
        rd && ps0 && psel[1] |=> !rdata_oe)
        else $error("direction register was read");
    AST_PORT_WRITE: assert property (@(posedge mclk) disable iff (!resetn || reset_pulse)
        wr_fall && ps0 && psel == 2'h0 |=> pa_q == $past(bus_q.wdata))
        else $error("port latch not written");
    AST_RDSTB_IDLE: assert property (@(posedge mclk) disable iff (!resetn)
        ##1 port_read_strobe_n)
        else $error("port read strobe driven");
endmodule : cbdhr_top

// *** cbdhr_top_tb.sv ***
// self-checking bench for the bus decode, port latches and halt reset glue
// assumes short POR and pulse counts; one queue of notes per bus cycle
`include "cbdhr_consts.svh"
`define CBDHR_CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin miscompares++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module cbdhr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [17:0] v; logic [17:0] m; } cbdhr_note_t;
    localparam int CYC = 16;
    logic mclk = 1'b0, resetn = 1'b0, sample_pulse, other_halt = 1'b0, host_reset_cmd = 1'b0, sw = 1'b0;
    logic [7:0] pa_in = 8'h00, pb_in = 8'h00, la_in = 8'h00, lb_in = 8'h00, ep_d = 8'h00, ram_d = 8'h00;
    logic [7:0] pa_o, pb_o, pa_d, pb_d, lo_a, lo_b, rdata, q_pa, q_pb, q_pad, q_pbd, q_la, q_lb;
    logic ums_n, lms_n, mid_n, ps0_n, ps1_n, ps2_n, ps3_n, ram_en, ram_io, prs_n, oe, halt_out, rst_n, f_rst, r_rst;
    cbdhr_pkg::cbdhr_bus_t bus;
    cbdhr_pkg::cbdhr_rstval_t rstval;
    cbdhr_note_t notes[$];
    int miscompares = 0, tests_run = 0, n, low_cnt = 0, halt_cnt = 0;
    localparam cbdhr_pkg::cbdhr_rstval_t rst_exp = {`CBDHR_RST_STATUS, `CBDHR_RST_ZERO, `CBDHR_RST_CODE_SEG,
        {3{`CBDHR_RST_ZERO}}, `CBDHR_RST_RELOC, `CBDHR_RST_UPPER_CFG, `CBDHR_FETCH_ADDR};
    integer seed = 32'h209438d8;
    always #4 mclk = ~mclk;
    // cycle counts of the cpu reset and the halt flag, read by the scenarios
    always @(negedge mclk) begin
        if (rst_n === 1'b0) low_cnt++;
        if (halt_out === 1'b1) halt_cnt++;
    end
    cbdhr_cpu_model cbdhr_cpu_model_inst (.mclk(mclk), .bus(bus), .sample_pulse(sample_pulse));
    cbdhr_top #(.PULSE_CYCLES(CYC), .POR_CYCLES(CYC)) cbdhr_top_inst (
        .mclk(mclk), .resetn(resetn), .bus_in(bus), .port_a_in(pa_in), .port_b_in(pb_in),
        .lo_port_a_in(la_in), .lo_port_b_in(lb_in), .eprom_rdata(ep_d), .ram_rdata(ram_d),
        .other_halt(other_halt), .host_reset_cmd(host_reset_cmd), .manual_computer_switch(sw),
        .upper_memory_select_n(ums_n), .lower_memory_select_n(lms_n), .midrange_select0_n(mid_n),
        .periph_select0_n(ps0_n), .periph_select1_n(ps1_n), .periph_select2_n(ps2_n), .periph_select3_n(ps3_n),
        .ram_chip_en(ram_en), .ram_io_mem(ram_io), .port_read_strobe_n(prs_n), .rdata(rdata), .rdata_oe(oe),
        .port_a_out(pa_o), .port_b_out(pb_o), .port_a_dir(pa_d), .port_b_dir(pb_d), .lo_port_a_out(lo_a),
        .lo_port_b_out(lo_b), .halt_out(halt_out), .cpu_reset_in_n(rst_n), .focus_reset_out(f_rst),
        .rotation_reset_out(r_rst), .cpu_rstval(rstval));
    wire [17:0] outs_seen = {ums_n, lms_n, mid_n, ps0_n, ps1_n, ps2_n, ps3_n, ram_en, ram_io, oe, rdata};
    wire [47:0] lat_seen = {pa_o, pb_o, pa_d, pb_d, lo_a, lo_b};
    // ----------------------------------------
    // expectations
    // ----------------------------------------
    function automatic logic [7:0] port_val(input logic lo, input logic b);
        logic [7:0] dir, out, pin;
        dir = b ? q_pbd : q_pad;
        out = lo ? (b ? q_lb : q_la) : (b ? q_pb : q_pa);
        pin = lo ? (b ? lb_in : la_in) : (b ? pb_in : pa_in);
        return (dir & out) | (~dir & pin);
    endfunction : port_val
    function automatic cbdhr_note_t expect_of(input logic io, input logic [19:0] a, input logic wr);
        cbdhr_note_t nt;
        logic [6:0] sel;
        logic [7:0] dv;
        logic rd_ok;
        sel = 7'h7F;
        rd_ok = 1'b0;
        dv = 8'h00;
        nt.m = 18'h3FFFF;
        if (!io) begin
            if (a >= `CBDHR_UPPER_LO) begin sel[6] = 1'b0; rd_ok = !wr; dv = ep_d; end
            else if (a >= `CBDHR_RAM_LO && a <= `CBDHR_RAM_HI) begin sel[4] = 1'b0; rd_ok = !wr; dv = ram_d; end
            else if (a <= `CBDHR_LOWER_HI) begin sel[5] = 1'b0; rd_ok = !wr; dv = ep_d; end
        end else if (a[19:9] == 11'h000) begin
            sel[3 - a[8:7]] = 1'b0;
            if (!a[8]) sel[6 - a[7]] = 1'b0; // port cycles also enable the eprom chip
            if (!a[8] && !a[1] && !wr) begin rd_ok = 1'b1; dv = port_val(a[7], a[0]); end
            if (a[8]) nt.m[8:0] = 9'h000; // ram io and strobe decoder reads are outside this block
        end
        if (!rd_ok) nt.m[7:0] = 8'h00;
        nt.v = {sel, !sel[4] || !sel[1], !sel[1], rd_ok, dv};
        return nt;
    endfunction : expect_of
    // ----------------------------------------
    // monitor: oldest note against outputs at the cpu sampling point
    // ----------------------------------------
    always @(posedge sample_pulse) begin
        if (notes.size() == 0) begin
            miscompares++;
            $display("MISMATCH note queue empty");
        end else begin
            cbdhr_note_t nt;
            logic [17:0] exp_v, got_v;
            nt = notes.pop_front();
            exp_v = nt.v & nt.m;
            got_v = outs_seen & nt.m;
            `CBDHR_CHK("chip selects", exp_v[17:11], got_v[17:11])
            `CBDHR_CHK("ram enables", exp_v[10:9], got_v[10:9])
            `CBDHR_CHK("read data", exp_v[8:0], got_v[8:0])
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    task automatic clear_model();
        {q_pa, q_pb, q_pad, q_pbd, q_la, q_lb} = {6{`CBDHR_PORT_RST}};
    endtask : clear_model
    task automatic op(input logic io, input logic [19:0] a, input logic wr, input logic [7:0] d, input logic [2:0] st);
        @(negedge mclk);
        {pa_in, pb_in, la_in, lb_in, ep_d, ram_d} = 48'({$random(seed), $random(seed)});
        notes.push_back(expect_of(io, a, wr));
        cbdhr_cpu_model_inst.run_cycle(io, a, wr, d, st);
        if (io && wr && a[19:8] == 12'h000) begin
            case ({a[7], a[1:0]})
                3'd0: q_pa = d;
                3'd1: q_pb = d;
                3'd4: q_la = d;
                3'd5: q_lb = d;
                3'd2, 3'd6: q_pad = d;
                default: q_pbd = d;
            endcase
        end
    endtask : op
    task automatic wait_rst(input logic lvl, output int cnt);
        cnt = 0;
        while (rst_n !== lvl) begin
            @(negedge mclk);
            cnt++;
            if (cnt > 200) begin
                miscompares++;
                $display("MISMATCH cpu reset wait expected %h", lvl);
                give_verdict();
            end
        end
    endtask : wait_rst
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    logic [19:0] mem_a[10] = '{20'hFF800, 20'hFFFFF, 20'hFF7FF, 20'h02000, 20'h020FF, 20'h02100, 20'h01FFF,
                               20'h00000, 20'h007FF, 20'h00800};
    logic [19:0] io_a[9] = '{20'h0000, 20'h007F, 20'h0080, 20'h00FF, 20'h0100, 20'h017F, 20'h0180, 20'h01FF,
                             20'h0200};
    initial begin
        clear_model();
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
        wait_rst(1'b1, n);
        `CBDHR_CHK("power on hold", 1'b1, n >= CYC)
        `CBDHR_CHK("reset values", rst_exp, rstval)
        `CBDHR_CHK("port read strobe", 1'b1, prs_n)
        foreach (mem_a[i]) op(1'b0, mem_a[i], 1'b0, 8'h00, 3'h7);
        foreach (io_a[i]) op(1'b1, io_a[i], 1'b0, 8'h00, 3'h7);
        op(1'b0, 20'h02080, 1'b1, 8'h5A, 3'h7);
        $display("test decode done");
        for (int i = 0; i < 8; i++) op(1'b1, {12'h000, i[2], 5'h00, i[1:0]}, 1'b1, 8'($random(seed)), 3'h7);
        `CBDHR_CHK("port latches", {q_pa, q_pb, q_pad, q_pbd, q_la, q_lb}, lat_seen)
        for (int i = 0; i < 8; i++) op(1'b1, {12'h000, i[2], 5'h00, i[1:0]}, 1'b0, 8'h00, 3'h7);
        for (int i = 0; i < 6; i++) op(1'b1, {4'h0, 16'h0200 | 16'($random(seed))}, 1'b0, 8'h00, 3'h7);
        `CBDHR_CHK("no spurious reset", 1'b1, rst_n)
        $display("test ports done");
        low_cnt = 0;
        op(1'b0, 20'hFFFF0, 1'b0, 8'h00, 3'b011);
        `CBDHR_CHK("halt trigger delay", 1'b1, low_cnt >= 8)
        `CBDHR_CHK("halt flag", 1, halt_cnt)
        @(negedge mclk);
        `CBDHR_CHK("both resets out", 2'b11, {f_rst, r_rst})
        wait_rst(1'b1, n);
        `CBDHR_CHK("pulse length", CYC, low_cnt)
        clear_model();
        `CBDHR_CHK("latch cleared", {6{`CBDHR_PORT_RST}}, lat_seen)
        $display("test halt done");
        for (int k = 0; k < 3; k++) begin
            @(negedge mclk);
            low_cnt = 0;
            if (k == 0) host_reset_cmd = 1'b1;
            if (k == 1) sw = ~sw;
            if (k == 2) other_halt = 1'b1;
            repeat (4) @(negedge mclk);
            {host_reset_cmd, other_halt} = 2'b00;
            wait_rst(1'b0, n);
            wait_rst(1'b1, n);
            `CBDHR_CHK("trigger pulse", CYC, low_cnt)
        end
        clear_model();
        op(1'b1, 20'h00000, 1'b1, 8'hC3, 3'h7);
        low_cnt = 0;
        op(1'b1, 20'h00000, 1'b0, 8'h00, 3'b011);
        wait_rst(1'b1, n);
        `CBDHR_CHK("rearmed", CYC, low_cnt)
        `CBDHR_CHK("halt flag again", 2, halt_cnt)
        $display("test triggers done");
        give_verdict();
    end
endmodule : cbdhr_top_tb
